// [rtl/slsf_pkg.sv]
// Contract
// - preload runs only if the first serial rom byte is the enable pattern
// - frames keep flowing during preload; register accesses wait until it ends
// - diagnostic port register accesses are refused until preload has completed
// - six links, each with its own receiver-driven sync machine steering transmit
// - four states call, ack, reply, linked; sync frame carries state, no sequence
// - call entered at reset or transmitter on; frames separated by four k28.5
// - transmit call at least 31250 cycles before judging reception
// - call or ack with good crc in window 31250..62500 moves to ack, else stop
// - ack frames per lane pair, four k28.5 between, report good-crc lane pairs
// - ack lasts at least 31250 cycles; stop if no good ack by 62500
// - early good ack moves to reply exactly at the 31250 cycle point
// - reply stripes over 1, 2 or 4 working lane pairs, four k28.5 between
// - reply waits up to 62500 cycles for good reply frame, else stop
// - good reply starts 1000 cycle timer, then linked
// - linked frame received in reply goes to linked at once
// - linked sends empty linked frames and may send data anytime
// - link off control keeps transmitter disabled regardless of received sync
// - enabled but failed link retries for 1ms every 500ms
// - stopped enabled transmitter turns on at good call; stays on if sync succeeds
// - after reset every link is enabled and begins synchronizing
// - clock comma recognized only after four comma characters on one lane pair
// - recognized comma is resent on all links and masks commas for 72.8us
// - propagated comma is four commas back to back on every lane pair
package slsf_pkg;
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned NUM_LINKS = 6;
  localparam int unsigned NUM_PAIRS = 4;
  // phase figures are in cycles of the 62.208MHz line clock, converted to mclk
  localparam int unsigned LINE_KHZ = 62208;
  localparam int unsigned CALL_MIN_LC = 31250;
  localparam int unsigned CALL_MAX_LC = 62500;
  localparam int unsigned ALIGN_LC = 1000;
  localparam int unsigned CALL_MIN_CYC = (CALL_MIN_LC * CLK_KHZ + LINE_KHZ - 1) / LINE_KHZ;
  localparam int unsigned CALL_MAX_CYC = (CALL_MAX_LC * CLK_KHZ) / LINE_KHZ;
  localparam int unsigned ALIGN_CYC = (ALIGN_LC * CLK_KHZ + LINE_KHZ - 1) / LINE_KHZ;
  localparam int unsigned RETRY_ON_MS = 1;
  localparam int unsigned RETRY_PERIOD_MS = 500;
  localparam int unsigned MASK_NS = 72800;
  localparam int unsigned MASK_CYC = (MASK_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int unsigned COMMA_RUN = 4;
  localparam int unsigned K285_GAP = 4;
  localparam logic [7:0] PRELOAD_MAGIC = 8'ha5;
  localparam int TW = 16;
  typedef enum logic [2:0] {
    SLSF_IDLE = 3'b000,
    SLSF_CALL = 3'b001,
    SLSF_ACK = 3'b010,
    SLSF_REPLY = 3'b011,
    SLSF_ALIGN = 3'b100,
    SLSF_LINKED = 3'b101
  } slsf_state_t;
  // behavior field codes carried in sync frames
  typedef enum logic [1:0] {
    SLSF_B_CALL = 2'b00,
    SLSF_B_ACK = 2'b01,
    SLSF_B_REPLY = 2'b10,
    SLSF_B_LINKED = 2'b11
  } slsf_beh_t;
  typedef enum logic [1:0] {
    SLSF_P_FETCH = 2'b00,
    SLSF_P_RUN = 2'b01,
    SLSF_P_DONE = 2'b10
  } slsf_pre_t;
endpackage : slsf_pkg

// [rtl/slsf_link_fsm.sv]
`timescale 1ns/10ps
module slsf_link_fsm
  import slsf_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = RETRY_PERIOD_MS * CLK_KHZ,
  parameter int unsigned ON_CYC = RETRY_ON_MS * CLK_KHZ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_off,
  input wire logic retry_pulse,
  input wire logic rx_call_good,
  input wire logic rx_ack_good,
  input wire logic rx_reply_good,
  input wire logic rx_linked_good,
  input wire logic [NUM_PAIRS-1:0] rx_pair_good,
  output slsf_state_t state,
  output logic tx_on,
  output logic [NUM_PAIRS-1:0] stripe_mask
);
  slsf_state_t state_ff;
  logic [TW-1:0] tmr_ff;
  logic ack_seen_ff;
  logic [NUM_PAIRS-1:0] good_ff;
  logic [NUM_PAIRS-1:0] nxt_stripe;
  int unsigned n;

  assign state = state_ff;
  assign tx_on = (state_ff != SLSF_IDLE) && !link_off;
  assign stripe_mask = good_ff;

  // stripe width must be a power of two; pick largest usable set
  always_comb begin
    n = 0;
    for (int i = 0; i < NUM_PAIRS; i++) n = n + (rx_pair_good[i] ? 1 : 0);
    if (n == NUM_PAIRS) nxt_stripe = '1;
    else if (rx_pair_good[0] && rx_pair_good[1]) nxt_stripe = 4'h3;
    else if (rx_pair_good[2] && rx_pair_good[3]) nxt_stripe = 4'hc;
    else if (rx_pair_good[0]) nxt_stripe = 4'h1;
    else if (rx_pair_good[1]) nxt_stripe = 4'h2;
    else if (rx_pair_good[2]) nxt_stripe = 4'h4;
    else nxt_stripe = rx_pair_good[3] ? 4'h8 : 4'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SLSF_CALL;
      tmr_ff <= '0;
      ack_seen_ff <= 1'b0;
      good_ff <= '0;
    end else if (link_off) begin
      state_ff <= SLSF_IDLE;
      tmr_ff <= '0;
      ack_seen_ff <= 1'b0;
    end else begin
      tmr_ff <= tmr_ff + 1'b1;
      case (state_ff)
        SLSF_IDLE: begin
          if (retry_pulse || rx_call_good) begin
            state_ff <= SLSF_CALL;
            tmr_ff <= '0;
          end
        end
        SLSF_CALL: begin
          if (tmr_ff >= TW'(CALL_MIN_CYC) && (rx_call_good || rx_ack_good)) begin
            state_ff <= SLSF_ACK;
            tmr_ff <= '0;
            ack_seen_ff <= 1'b0;
          end else if (tmr_ff >= TW'(CALL_MAX_CYC)) begin
            state_ff <= SLSF_IDLE;
          end
        end
        SLSF_ACK: begin
          if (rx_ack_good) ack_seen_ff <= 1'b1;
          good_ff <= rx_pair_good;
          if (tmr_ff >= TW'(CALL_MIN_CYC) && (ack_seen_ff || rx_ack_good)) begin
            state_ff <= SLSF_REPLY;
            tmr_ff <= '0;
            good_ff <= nxt_stripe;
          end else if (tmr_ff >= TW'(CALL_MAX_CYC)) begin
            state_ff <= SLSF_IDLE;
          end
        end
        SLSF_REPLY: begin
          if (rx_linked_good) begin
            state_ff <= SLSF_LINKED;
          end else if (rx_reply_good) begin
            state_ff <= SLSF_ALIGN;
            tmr_ff <= '0;
          end else if (tmr_ff >= TW'(CALL_MAX_CYC)) begin
            state_ff <= SLSF_IDLE;
          end
        end
        SLSF_ALIGN: begin
          if (rx_linked_good || tmr_ff >= TW'(ALIGN_CYC - 1)) state_ff <= SLSF_LINKED;
        end
        SLSF_LINKED: tmr_ff <= '0;
        default: state_ff <= SLSF_IDLE;
      endcase
    end
  end
endmodule : slsf_link_fsm

// [rtl/slsf_top.sv]
`timescale 1ns/10ps
module slsf_top
  import slsf_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = RETRY_PERIOD_MS * CLK_KHZ,
  parameter int unsigned ON_CYC = RETRY_ON_MS * CLK_KHZ
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NUM_LINKS-1:0] link_off,
  input wire logic [NUM_LINKS-1:0] rx_call_good,
  input wire logic [NUM_LINKS-1:0] rx_ack_good,
  input wire logic [NUM_LINKS-1:0] rx_reply_good,
  input wire logic [NUM_LINKS-1:0] rx_linked_good,
  input wire logic [NUM_LINKS*NUM_PAIRS-1:0] rx_pair_good,
  input wire logic [NUM_LINKS*NUM_PAIRS-1:0] rx_comma,
  input wire logic rom_valid,
  input wire logic [7:0] rom_byte,
  input wire logic rom_done,
  input wire logic diag_req,
  input wire logic host_req,
  output logic [NUM_LINKS*3-1:0] link_state,
  output logic [NUM_LINKS*2-1:0] tx_behavior,
  output logic [NUM_LINKS-1:0] tx_on,
  output logic [NUM_LINKS*NUM_PAIRS-1:0] tx_stripe,
  output logic [2:0] tx_k285_gap,
  output logic tx_comma,
  output logic preload_busy,
  output logic diag_ack,
  output logic diag_refused,
  output logic host_grant
);
  logic rs1_ff;
  logic rst_n;
  logic [1:0] settle_ff;
  logic [NUM_LINKS-1:0] off_s1_ff, off_s2_ff;
  logic [NUM_LINKS-1:0] call_s1_ff, call_s2_ff, ack_s1_ff, ack_s2_ff;
  logic [NUM_LINKS-1:0] rep_s1_ff, rep_s2_ff, lnk_s1_ff, lnk_s2_ff;
  logic [NUM_LINKS*NUM_PAIRS-1:0] pg_s1_ff, pg_s2_ff, cm_s1_ff, cm_s2_ff;
  logic [31:0] per_ff;
  logic retry_ff;
  slsf_pre_t pre_ff;
  logic [NUM_LINKS*NUM_PAIRS*3-1:0] run_ff;
  logic [TW-1:0] mask_ff;
  logic [2:0] burst_ff;
  slsf_state_t st [NUM_LINKS];
  logic [NUM_LINKS-1:0] on_w;
  logic [NUM_LINKS*NUM_PAIRS-1:0] stripe_w;
  logic [NUM_LINKS*NUM_PAIRS-1:0] run_hit;

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_n <= rs1_ff;
    end
  end

  // link off pins need two cycles to reach the machines; keep transmitters quiet meanwhile
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) settle_ff <= '0;
    else settle_ff <= {settle_ff[0], 1'b1};
  end

  // link-side inputs come from another domain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {off_s1_ff, off_s2_ff, call_s1_ff, call_s2_ff, ack_s1_ff, ack_s2_ff} <= '0;
      {rep_s1_ff, rep_s2_ff, lnk_s1_ff, lnk_s2_ff} <= '0;
      {pg_s1_ff, pg_s2_ff, cm_s1_ff, cm_s2_ff} <= '0;
    end else begin
      off_s1_ff <= link_off;
      off_s2_ff <= off_s1_ff;
      call_s1_ff <= rx_call_good;
      call_s2_ff <= call_s1_ff;
      ack_s1_ff <= rx_ack_good;
      ack_s2_ff <= ack_s1_ff;
      rep_s1_ff <= rx_reply_good;
      rep_s2_ff <= rep_s1_ff;
      lnk_s1_ff <= rx_linked_good;
      lnk_s2_ff <= lnk_s1_ff;
      pg_s1_ff <= rx_pair_good;
      pg_s2_ff <= pg_s1_ff;
      cm_s1_ff <= rx_comma;
      cm_s2_ff <= cm_s1_ff;
    end
  end

  // one shared retry pulse: a single cycle at the start of each 500ms period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      per_ff <= '0;
      retry_ff <= 1'b0;
    end else begin
      per_ff <= (per_ff >= 32'(PERIOD_CYC - 1)) ? '0 : per_ff + 1'b1;
      retry_ff <= (per_ff == 32'(PERIOD_CYC - 1));
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : g_link
      slsf_link_fsm #(.PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC)) u_fsm (
        .mclk(mclk),
        .rst_n(rst_n),
        .link_off(off_s2_ff[g]),
        .retry_pulse(retry_ff),
        .rx_call_good(call_s2_ff[g]),
        .rx_ack_good(ack_s2_ff[g]),
        .rx_reply_good(rep_s2_ff[g]),
        .rx_linked_good(lnk_s2_ff[g]),
        .rx_pair_good(pg_s2_ff[g*NUM_PAIRS +: NUM_PAIRS]),
        .state(st[g]),
        .tx_on(on_w[g]),
        .stripe_mask(stripe_w[g*NUM_PAIRS +: NUM_PAIRS])
      );
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          link_state[g*3 +: 3] <= SLSF_CALL;
          tx_behavior[g*2 +: 2] <= SLSF_B_CALL;
          tx_on[g] <= 1'b0;
          tx_stripe[g*NUM_PAIRS +: NUM_PAIRS] <= '0;
        end else begin
          link_state[g*3 +: 3] <= st[g];
          tx_on[g] <= on_w[g] && settle_ff[1];
          case (st[g])
            SLSF_ACK: tx_behavior[g*2 +: 2] <= SLSF_B_ACK;
            SLSF_REPLY, SLSF_ALIGN: tx_behavior[g*2 +: 2] <= SLSF_B_REPLY;
            SLSF_LINKED: tx_behavior[g*2 +: 2] <= SLSF_B_LINKED;
            default: tx_behavior[g*2 +: 2] <= SLSF_B_CALL;
          endcase
          // call and ack run every pair alone; later phases stripe
          if (st[g] == SLSF_CALL || st[g] == SLSF_ACK) tx_stripe[g*NUM_PAIRS +: NUM_PAIRS] <= '0;
          else tx_stripe[g*NUM_PAIRS +: NUM_PAIRS] <= stripe_w[g*NUM_PAIRS +: NUM_PAIRS];
        end
      end
    end
    // per lane pair run length of consecutive commas
    for (g = 0; g < NUM_LINKS * NUM_PAIRS; g++) begin : g_pair
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) run_ff[g*3 +: 3] <= '0;
        else if (!cm_s2_ff[g]) run_ff[g*3 +: 3] <= '0;
        else if (run_ff[g*3 +: 3] != 3'(COMMA_RUN)) run_ff[g*3 +: 3] <= run_ff[g*3 +: 3] + 1'b1;
      end
      // only operational pairs count
      assign run_hit[g] = (run_ff[g*3 +: 3] == 3'(COMMA_RUN - 1)) && cm_s2_ff[g] && pg_s2_ff[g];
    end
  endgenerate

  // fixed gap, still launched from a flop like every other output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tx_k285_gap <= 3'(K285_GAP);
    else tx_k285_gap <= 3'(K285_GAP);
  end

  // clock comma mask timer and four-comma outbound burst
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
      burst_ff <= '0;
      tx_comma <= 1'b0;
    end else begin
      if (mask_ff != '0) mask_ff <= mask_ff - 1'b1;
      else if (|run_hit) begin
        mask_ff <= TW'(MASK_CYC);
        burst_ff <= 3'(COMMA_RUN);
      end
      if (burst_ff != '0) burst_ff <= burst_ff - 1'b1;
      tx_comma <= (burst_ff != '0);
    end
  end

  // serial preload gate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= SLSF_P_FETCH;
      preload_busy <= 1'b1;
      diag_ack <= 1'b0;
      diag_refused <= 1'b0;
      host_grant <= 1'b0;
    end else begin
      case (pre_ff)
        SLSF_P_FETCH: if (rom_valid) pre_ff <= (rom_byte == PRELOAD_MAGIC) ? SLSF_P_RUN : SLSF_P_DONE;
        SLSF_P_RUN: if (rom_done) pre_ff <= SLSF_P_DONE;
        SLSF_P_DONE: pre_ff <= SLSF_P_DONE;
        default: pre_ff <= SLSF_P_DONE;
      endcase
      preload_busy <= (pre_ff != SLSF_P_DONE);
      diag_ack <= diag_req && (pre_ff == SLSF_P_DONE);
      diag_refused <= diag_req && (pre_ff != SLSF_P_DONE);
      // request is held by its source until granted; frames are not gated here
      host_grant <= host_req && (pre_ff == SLSF_P_DONE);
    end
  end
endmodule : slsf_top

// [test/slsf_top_properties.sv]
`timescale 1ns/10ps
module slsf_top_properties
  import slsf_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = 5000,
  parameter int unsigned ON_CYC = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NUM_LINKS-1:0] link_off,
  input wire logic [NUM_LINKS*3-1:0] link_state,
  input wire logic [NUM_LINKS*2-1:0] tx_behavior,
  input wire logic [NUM_LINKS-1:0] tx_on,
  input wire logic [NUM_LINKS*NUM_PAIRS-1:0] tx_stripe,
  input wire logic [2:0] tx_k285_gap,
  input wire logic tx_comma,
  input wire logic preload_busy,
  input wire logic diag_ack
);
  // only link 0 is timed; the others share the same machine
  wire logic [2:0] st0 = link_state[2:0];
  logic [2:0] st_q_ff;
  logic [31:0] run_ff;
  logic [31:0] gap_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q_ff <= 3'h1;
      run_ff <= '0;
    end else begin
      st_q_ff <= st0;
      run_ff <= (st0 == st_q_ff) ? run_ff + 32'h1 : 32'h0;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff <= '1;
    end else begin
      gap_ff <= tx_comma ? 32'h0 : gap_ff + {31'h0, ~&gap_ff};
    end
  end
  sequence s_burst;
    tx_comma [*4] ##1 !tx_comma;
  endsequence
  property p_burst;
    $rose(tx_comma) |-> s_burst;
  endproperty
  a_burst: assert property (p_burst) else $error("comma burst length");
  property p_mask;
    $rose(tx_comma) |-> gap_ff >= MASK_CYC - 8;
  endproperty
  a_mask: assert property (p_mask) else $error("comma inside mask");
  property p_call_min;
    st0 == 3'h2 && st_q_ff == 3'h1 |-> run_ff >= CALL_MIN_CYC - 2;
  endproperty
  a_call_min: assert property (p_call_min) else $error("call too short");
  property p_ack_exact;
    st0 == 3'h3 && st_q_ff == 3'h2 |-> run_ff inside {[CALL_MIN_CYC-3:CALL_MIN_CYC+2]};
  endproperty
  a_ack_exact: assert property (p_ack_exact) else $error("ack length");
  property p_max;
    st0 == 3'h2 || st0 == 3'h3 |-> run_ff <= CALL_MAX_CYC + 2;
  endproperty
  a_max: assert property (p_max) else $error("phase too long");
  property p_align;
    st0 == 3'h5 && st_q_ff == 3'h4 |-> run_ff inside {[ALIGN_CYC-3:ALIGN_CYC+2]};
  endproperty
  a_align: assert property (p_align) else $error("align length");
  property p_off;
    link_off[4] [*6] |-> !tx_on[4];
  endproperty
  a_off: assert property (p_off) else $error("tx on while off");
  property p_beh;
    st0 == st_q_ff && st0 inside {3'h1, 3'h5} |->
      tx_behavior[1:0] == ((st0 == 3'h5) ? SLSF_B_LINKED : SLSF_B_CALL);
  endproperty
  a_beh: assert property (p_beh) else $error("behavior field");
  property p_stripe;
    st0 == st_q_ff && st0 inside {3'h1, 3'h2} |-> tx_stripe[3:0] == 4'h0;
  endproperty
  a_stripe: assert property (p_stripe) else $error("stripe early");
  property p_gap;
    tx_k285_gap == 3'h4;
  endproperty
  a_gap: assert property (p_gap) else $error("k285 gap");
  property p_diag;
    preload_busy && $past(preload_busy) |-> !diag_ack;
  endproperty
  a_diag: assert property (p_diag) else $error("diag during preload");
endmodule : slsf_top_properties

bind slsf_top slsf_top_properties #(.PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .link_off(link_off), .link_state(link_state),
  .tx_behavior(tx_behavior), .tx_on(tx_on), .tx_stripe(tx_stripe), .tx_k285_gap(tx_k285_gap),
  .tx_comma(tx_comma), .preload_busy(preload_busy), .diag_ack(diag_ack));

// [test/slsf_peer_model.sv]
`timescale 1ns/10ps
module slsf_peer_model
  import slsf_pkg::*;
(
  input wire logic mclk,
  input wire logic [NUM_LINKS-1:0] answer_en,
  input wire logic [NUM_LINKS-1:0] fast_en,
  input wire logic [NUM_LINKS-1:0] tx_on,
  input wire logic [NUM_LINKS*2-1:0] tx_behavior,
  output logic [NUM_LINKS-1:0] rx_call_good,
  output logic [NUM_LINKS-1:0] rx_ack_good,
  output logic [NUM_LINKS-1:0] rx_reply_good,
  output logic [NUM_LINKS-1:0] rx_linked_good,
  output logic [NUM_LINKS*NUM_PAIRS-1:0] rx_pair_good
);
  // peer mirrors our phase; a silent peer is answer_en low
  initial begin
    {rx_call_good, rx_ack_good, rx_reply_good, rx_linked_good, rx_pair_good} = '0;
    forever begin
      @(negedge mclk);
      for (int i = 0; i < NUM_LINKS; i++) begin : lnk
        logic [1:0] b;
        logic on;
        b = tx_behavior[2*i +: 2];
        on = tx_on[i] & answer_en[i];
        rx_call_good[i] <= answer_en[i] & (~tx_on[i] | (b == SLSF_B_CALL));
        rx_ack_good[i] <= on & (b == SLSF_B_ACK);
        rx_reply_good[i] <= on & (b == SLSF_B_REPLY);
        rx_linked_good[i] <= on & ((b == SLSF_B_LINKED) | (fast_en[i] & (b == SLSF_B_REPLY)));
        // link 2 loses its top pair so a narrower stripe gets exercised
        rx_pair_good[NUM_PAIRS*i +: NUM_PAIRS] <= {NUM_PAIRS{on}} & ((i == 2) ? 4'h7 : 4'hf);
      end
    end
  end
endmodule : slsf_peer_model

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
  import slsf_pkg::*;
  logic mclk;
  logic arst_n = 1'b0;
  logic [5:0] link_off = 6'h10;
  logic [5:0] ans_en = 6'h17;
  logic [5:0] fast_en = 6'h02;
  logic [23:0] rx_comma = '0;
  logic rom_valid = 1'b0;
  logic [7:0] rom_byte = 8'h00;
  logic rom_done = 1'b0;
  logic diag_req = 1'b0;
  logic host_req = 1'b0;
  logic [5:0] call_g, ack_g, reply_g, linked_g, tx_on;
  logic [23:0] pair_g, tx_stripe;
  logic [17:0] link_state;
  logic [11:0] tx_behavior;
  logic [2:0] tx_k285_gap;
  logic tx_comma, preload_busy, diag_ack, diag_refused, host_grant;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_comma = 0;
  slsf_top #(.PERIOD_CYC(5000)) dut_u (.mclk(mclk), .arst_n(arst_n), .link_off(link_off),
    .rx_call_good(call_g), .rx_ack_good(ack_g), .rx_reply_good(reply_g), .rx_linked_good(linked_g),
    .rx_pair_good(pair_g), .rx_comma(rx_comma), .rom_valid(rom_valid), .rom_byte(rom_byte),
    .rom_done(rom_done), .diag_req(diag_req), .host_req(host_req), .link_state(link_state),
    .tx_behavior(tx_behavior), .tx_on(tx_on), .tx_stripe(tx_stripe), .tx_k285_gap(tx_k285_gap),
    .tx_comma(tx_comma), .preload_busy(preload_busy), .diag_ack(diag_ack),
    .diag_refused(diag_refused), .host_grant(host_grant));
  slsf_peer_model peer_u (.mclk(mclk), .answer_en(ans_en), .fast_en(fast_en), .tx_on(tx_on),
    .tx_behavior(tx_behavior), .rx_call_good(call_g), .rx_ack_good(ack_g), .rx_reply_good(reply_g),
    .rx_linked_good(linked_g), .rx_pair_good(pair_g));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ceiling sized for one full link-up plus one retry period
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (tx_comma === 1'b1) begin
      n_comma <= n_comma + 1;
    end
    if (cyc == 45000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick
  task automatic wait_st(input int l, input logic [2:0] v, input int lim, output int n);
    n = 0;
    while (link_state[3*l +: 3] !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(link_state[3*l +: 3], v);
  endtask : wait_st
  task automatic do_reset(input logic [7:0] b);
    arst_n = 1'b0;
    tick(3);
    arst_n = 1'b1;
    tick(3);
    chk(tx_on[4], 1'b0);
    tick(1);
    rom_byte = b;
    rom_valid = 1'b1;
    tick(1);
    rom_valid = 1'b0;
  endtask : do_reset
  task automatic t_preload();
    int k;
    do_reset(8'h00);
    tick(8);
    chk(preload_busy, 1'b0);
    do_reset(PRELOAD_MAGIC);
    diag_req = 1'b1;
    host_req = 1'b1;
    tick(20);
    chk(preload_busy, 1'b1);
    chk({diag_refused, diag_ack}, 2'b10);
    chk(host_grant, 1'b0);
    chk({tx_on[0], link_state[2:0]}, 4'h9);
    rom_done = 1'b1;
    tick(1);
    rom_done = 1'b0;
    k = 0;
    while (host_grant !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
    chk(host_grant, 1'b1);
    chk({diag_refused, diag_ack}, 2'b01);
    host_req = 1'b0;
    diag_req = 1'b0;
  endtask : t_preload
  task automatic t_sync();
    int n;
    wait_st(0, 3'h2, 13000, n);
    chk(n > 12480, 1'b1);
    wait_st(0, 3'h3, 12700, n);
    chk(n > 12500, 1'b1);
    tick(5);
    chk(tx_stripe[3:0], 4'hf);
    chk(tx_stripe[11:8], 4'h3);
    wait_st(1, 3'h5, 40, n);
    chk(link_state[2:0], 3'h4);
    wait_st(0, 3'h5, 500, n);
    chk(n > 390, 1'b1);
    chk(tx_behavior[1:0], SLSF_B_LINKED);
    chk(tx_on[4], 1'b0);
    wait_st(5, 3'h0, 26000, n);
    ans_en[5] = 1'b1;
    wait_st(5, 3'h1, 20, n);
    wait_st(3, 3'h0, 100, n);
    chk(tx_on[3], 1'b0);
    wait_st(3, 3'h1, 5100, n);
    tick(2);
    chk(tx_on[3], 1'b1);
  endtask : t_sync
  task automatic comma(input int p, input int k);
    rx_comma[p] = 1'b1;
    tick(k);
    rx_comma[p] = 1'b0;
    tick(16);
  endtask : comma
  task automatic t_comma();
    // link 3 pair 0 delivers no good crc, so its commas must not count
    comma(12, 4);
    chk(n_comma, 0);
    comma(0, 3);
    chk(n_comma, 0);
    comma(0, 4);
    chk(n_comma, 4);
    comma(0, 4);
    chk(n_comma, 4);
    tick(1850);
    comma(0, 4);
    chk(n_comma, 8);
  endtask : t_comma
  initial begin
    t_preload();
    t_sync();
    t_comma();
    report_and_stop();
  end
endmodule : tb
